/* core/mrt_pkg.sv */
package mrt_pkg;

    // Mode register select codes and the one never to be used
    localparam logic [2:0] MRT_SEL_SECOND   = 3'h2;
    localparam logic [2:0] MRT_SEL_THIRD    = 3'h3;
    localparam logic [2:0] MRT_SEL_DNU      = 3'h7;

    // Field positions in the 22-bit register word
    localparam int MRT_SEL_LSB    = 18;
    localparam int MRT_CRC_BIT    = 12;
    localparam int MRT_WTERM_LSB  = 9;
    localparam int MRT_SRR_LSB    = 6;
    localparam int MRT_CWD_LSB    = 3;
    localparam int MRT_MPRF_LSB   = 11;
    localparam int MRT_WCL_LSB    = 9;

    // Reserved bits, per register
    localparam logic [21:0] MRT_SECOND_RSV_MASK = 22'h000107;
    localparam logic [21:0] MRT_THIRD_RSV_MASK  = 22'h222000;

    // Reset values of the stored fields
    localparam logic [2:0] MRT_WTERM_RST = 3'h0;
    localparam logic [1:0] MRT_SRR_RST   = 2'h0;
    localparam logic [2:0] MRT_CWD_RST   = 3'h0;
    localparam logic [1:0] MRT_MPRF_RST  = 2'h0;
    localparam logic [1:0] MRT_WCL_RST   = 2'h0;

    // Write termination codes
    localparam logic [2:0] MRT_WTERM_OFF  = 3'h0;
    localparam logic [2:0] MRT_WTERM_MAX  = 3'h4;

    // Self-refresh range code selecting automatic switching
    localparam logic [1:0] MRT_SRR_AUTO   = 2'h3;

    // Write CAS delay table, one-clock preamble, and the two-clock floor
    localparam logic [4:0] MRT_CWD_TABLE [8] = '{5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0E, 5'h10, 5'h12, 5'h14};
    localparam logic [2:0] MRT_CWD_PRE2_MIN  = 3'h4;

    // Write command latency base and reserved code, and the readout format reserved code
    localparam logic [2:0] MRT_WCL_BASE  = 3'h4;
    localparam logic [1:0] MRT_WCL_RSV   = 2'h3;
    localparam logic [1:0] MRT_MPRF_RSV  = 2'h3;

    // Write frame lengths in unit intervals
    localparam logic [3:0] MRT_FRAME_PLAIN = 4'h8;
    localparam logic [3:0] MRT_FRAME_CRC   = 4'hA;

    // Command and address pins seen at the link
    typedef struct packed {
        logic       cs_n;
        logic       act_n;
        logic       ras_n;
        logic       cas_n;
        logic       we_n;
        logic [1:0] bg;
        logic [1:0] ba;
        logic       a17;
        logic [13:0] a;
    } mrt_pins_s;

    // Source of the termination applied right now
    typedef enum logic [1:0] {
        MRT_TERM_NOMINAL,
        MRT_TERM_WRITE
    } mrt_term_e;

endpackage

/* core/mrt_link_capture.sv */
`timescale 1ns/1ps
module mrt_link_capture (
    // Link clock and reset
    input  wire logic              link_clk_i,
    input  wire logic              rst_n_i,
    // Command pins
    input  wire mrt_pkg::mrt_pins_s pins_i,
    // Crossing to the core
    input  wire logic              ack_tgl_i,
    output logic                   req_tgl_o,
    output logic [21:0]            word_o
);
    import mrt_pkg::*;

    logic        req_d,  req_q;
    logic [21:0] word_d, word_q;
    logic        busy_d, busy_q;
    logic        ack_s1_q, ack_s2_q, ack_s3_q;
    logic        is_mrs;

    assign req_tgl_o = req_q;
    assign word_o    = word_q;

    always_comb begin
        // Mode register set: select low, all three strobes low
        is_mrs = !pins_i.cs_n && pins_i.act_n && !pins_i.ras_n && !pins_i.cas_n && !pins_i.we_n;
        req_d  = req_q;
        word_d = word_q;
        busy_d = busy_q;
        if (busy_q && (ack_s2_q == ack_s3_q) && (ack_s3_q == req_q)) begin
            busy_d = 1'b0;
        end
        // Word stays frozen while the core has not acknowledged it
        if (is_mrs && !busy_q) begin
            word_d = {pins_i.bg, pins_i.ba, pins_i.a17, 3'h0, pins_i.a};
            req_d  = !req_q;
            busy_d = 1'b1;
        end
    end

    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_q    <= 1'b0;
            word_q   <= 22'h000000;
            busy_q   <= 1'b0;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            ack_s3_q <= 1'b0;
        end else begin
            req_q    <= req_d;
            word_q   <= word_d;
            busy_q   <= busy_d;
            ack_s1_q <= ack_tgl_i;
            ack_s2_q <= ack_s1_q;
            ack_s3_q <= ack_s2_q;
        end
    end

endmodule

/* core/mrt_mode_regs.sv */
`timescale 1ns/1ps
// Behaviour
// - bits 11:9 select write termination strength
// - code 000 leaves termination untouched
// - bits 7:6 pick self-refresh temperature range
// - one-clock preamble delay table 9 to 20
// - two-clock preamble allows only codes 4-7
// - write delay counted in whole cycles
// - overall delay is additive+parity+write CAS
// - termination switches for writes without command
// - write leveling uses nominal termination only
// - CRC stretches write frame to ten UIs
// - bank and address pins carry register bits
// - bits 20:18 choose register, 111 unused
// - bits 12:11 select readout store format
// - bits 10:9 give write command latency
// - only needed settings may be supported
// - write termination applies with nominal off
module mrt_mode_regs (
    // Core clock and reset
    input  wire logic               mclk_i,
    input  wire logic               rst_n_i,
    // Link clock and command pins
    input  wire logic               link_clk_i,
    input  wire mrt_pkg::mrt_pins_s pins_i,
    // Device state from the same clock
    input  wire logic               preamble_2ck_i,
    input  wire logic               gear_down_i,
    input  wire logic               write_active_i,
    input  wire logic               write_leveling_i,
    input  wire logic [2:0]         nominal_termination_value_i,
    input  wire logic [4:0]         additive_delay_i,
    input  wire logic [2:0]         parity_delay_i,
    // Decoded settings
    output logic [2:0]              write_termination_value_o,
    output logic                    dynamic_term_en_o,
    output logic [2:0]              active_term_code_o,
    output mrt_pkg::mrt_term_e      active_term_src_o,
    output logic [1:0]              low_power_self_refresh_range_o,
    output logic                    automatic_range_self_refresh_o,
    output logic [4:0]              write_cas_delay_o,
    output logic                    write_cas_delay_ok_o,
    output logic [6:0]              overall_write_delay_o,
    output logic                    write_crc_en_o,
    output logic [3:0]              write_frame_ui_o,
    output logic [1:0]              mpr_read_format_o,
    output logic [2:0]              write_cmd_latency_o,
    output logic                    config_error_o,
    output logic                    reserved_bit_seen_o
);
    import mrt_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Write CAS delay lookup; zero marks a code that is not available
    function automatic logic [4:0] cwd_lookup(input logic [2:0] code, input logic pre2);
        logic [4:0] val;
        val = MRT_CWD_TABLE[code];
        if (pre2 && (code < MRT_CWD_PRE2_MIN)) begin
            val = 5'h00;
        end
        return val;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Codes 001 to 100 are real strengths; 000 and the reserved ones disable it
    function automatic logic wterm_usable(input logic [2:0] code);
        return (code != MRT_WTERM_OFF) && (code <= MRT_WTERM_MAX);
    endfunction

    // A reserved bit set anywhere in a register word
    function automatic logic rsv_hit(input logic [21:0] word, input logic [21:0] mask);
        return |(word & mask);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Link side capture
    logic        req_tgl;
    logic [21:0] link_word;
    logic        ack_d, ack_q;

    // Commands landing while a word is in flight are dropped; space them out
    mrt_link_capture u_link (
        .link_clk_i (link_clk_i),
        .rst_n_i    (rst_n_i),
        .pins_i     (pins_i),
        .ack_tgl_i  (ack_q),
        .req_tgl_o  (req_tgl),
        .word_o     (link_word)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Crossing into the core clock
    logic req_s1_q, req_s2_q, req_s3_q;
    logic new_word;

    // Word from the link is only read once the request toggle has settled
    assign new_word = (req_s2_q == req_s3_q) && (req_s3_q != ack_q);

    always_comb begin
        ack_d = ack_q;
        if (new_word) begin
            ack_d = req_s3_q;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
            ack_q    <= 1'b0;
        end else begin
            req_s1_q <= req_tgl;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
            ack_q    <= ack_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stored fields of the two registers
    logic [2:0] wterm_d, wterm_q;
    logic [1:0] srr_d,   srr_q;
    logic [2:0] cwd_d,   cwd_q;
    logic       crc_d,   crc_q;
    logic [1:0] mprf_d,  mprf_q;
    logic [1:0] wcl_d,   wcl_q;
    logic       rsv_d,   rsv_q;
    logic [2:0] sel;

    always_comb begin
        sel     = link_word[MRT_SEL_LSB +: 3];
        wterm_d = wterm_q;
        srr_d   = srr_q;
        cwd_d   = cwd_q;
        crc_d   = crc_q;
        mprf_d  = mprf_q;
        wcl_d   = wcl_q;
        rsv_d   = rsv_q;
        // Other selects, the unused code among them, leave both untouched
        if (new_word && (sel == MRT_SEL_SECOND)) begin
            wterm_d = link_word[MRT_WTERM_LSB +: 3];
            srr_d   = link_word[MRT_SRR_LSB +: 2];
            cwd_d   = link_word[MRT_CWD_LSB +: 3];
            crc_d   = link_word[MRT_CRC_BIT];
            rsv_d   = rsv_hit(link_word, MRT_SECOND_RSV_MASK);
        end else if (new_word && (sel == MRT_SEL_THIRD)) begin
            mprf_d  = link_word[MRT_MPRF_LSB +: 2];
            wcl_d   = link_word[MRT_WCL_LSB +: 2];
            rsv_d   = rsv_hit(link_word, MRT_THIRD_RSV_MASK);
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wterm_q <= MRT_WTERM_RST;
            srr_q   <= MRT_SRR_RST;
            cwd_q   <= MRT_CWD_RST;
            crc_q   <= 1'b0;
            mprf_q  <= MRT_MPRF_RST;
            wcl_q   <= MRT_WCL_RST;
            rsv_q   <= 1'b0;
        end else begin
            wterm_q <= wterm_d;
            srr_q   <= srr_d;
            cwd_q   <= cwd_d;
            crc_q   <= crc_d;
            mprf_q  <= mprf_d;
            wcl_q   <= wcl_d;
            rsv_q   <= rsv_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Termination group, registered toward the data bus
    logic [2:0]  out_wterm_d;
    logic        dyn_d;
    logic [2:0]  act_code_d;
    mrt_term_e   act_src_d;

    always_comb begin
        out_wterm_d = wterm_q;
        // Reserved termination codes are treated as disabled
        dyn_d       = wterm_usable(wterm_q);
        act_code_d  = nominal_termination_value_i;
        act_src_d   = MRT_TERM_NOMINAL;
        // No command needed: the write itself flips the strength
        if (write_active_i && dyn_d && !write_leveling_i) begin
            act_code_d = wterm_q;
            act_src_d  = MRT_TERM_WRITE;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            write_termination_value_o <= MRT_WTERM_RST;
            dynamic_term_en_o         <= 1'b0;
            active_term_code_o        <= 3'h0;
            active_term_src_o         <= MRT_TERM_NOMINAL;
        end else begin
            write_termination_value_o <= out_wterm_d;
            dynamic_term_en_o         <= dyn_d;
            active_term_code_o        <= act_code_d;
            active_term_src_o         <= act_src_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Latency group: write CAS delay, overall write delay, command latency
    logic [4:0]  cwl_d;
    logic        cwl_ok_d;
    logic [6:0]  wl_d;
    logic [2:0]  wcl_cyc_d;

    always_comb begin
        // Zero from the lookup marks a code not offered with this preamble
        cwl_d     = cwd_lookup(cwd_q, preamble_2ck_i);
        cwl_ok_d  = (cwl_d != 5'h00);
        // Sum kept wide enough for the largest additive and parity delays
        wl_d      = 7'(additive_delay_i) + 7'(parity_delay_i) + 7'(cwl_d);
        wcl_cyc_d = MRT_WCL_BASE + 3'(wcl_q);
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            write_cas_delay_o     <= 5'h00;
            write_cas_delay_ok_o  <= 1'b0;
            overall_write_delay_o <= 7'h00;
            write_cmd_latency_o   <= MRT_WCL_BASE;
        end else begin
            write_cas_delay_o     <= cwl_d;
            write_cas_delay_ok_o  <= cwl_ok_d;
            overall_write_delay_o <= wl_d;
            write_cmd_latency_o   <= wcl_cyc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode group: self-refresh range, CRC framing, readout format
    logic [1:0]  out_srr_d;
    logic        auto_d;
    logic        out_crc_d;
    logic [3:0]  frame_d;
    logic [1:0]  out_mprf_d;

    always_comb begin
        out_srr_d  = srr_q;
        auto_d     = (srr_q == MRT_SRR_AUTO);
        out_crc_d  = crc_q;
        // Length only announced; the data path appends the two CRC intervals
        frame_d    = crc_q ? MRT_FRAME_CRC : MRT_FRAME_PLAIN;
        out_mprf_d = mprf_q;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_power_self_refresh_range_o <= MRT_SRR_RST;
            automatic_range_self_refresh_o <= 1'b0;
            write_crc_en_o                 <= 1'b0;
            write_frame_ui_o               <= MRT_FRAME_PLAIN;
            mpr_read_format_o              <= MRT_MPRF_RST;
        end else begin
            low_power_self_refresh_range_o <= out_srr_d;
            automatic_range_self_refresh_o <= auto_d;
            write_crc_en_o                 <= out_crc_d;
            write_frame_ui_o               <= frame_d;
            mpr_read_format_o              <= out_mprf_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status group: misuse and reserved-bit flags
    logic        err_d;
    logic        out_rsv_d;

    always_comb begin
        // Gear-down misuse flagged only; the controller must avoid it
        err_d     = ((wterm_q != MRT_WTERM_OFF) && !wterm_usable(wterm_q))
                    || (cwl_d == 5'h00)
                    || (mprf_q == MRT_MPRF_RSV)
                    || (wcl_q == MRT_WCL_RSV)
                    || (gear_down_i && !cwd_q[0] && !cwd_q[2]);
        out_rsv_d = rsv_q;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            config_error_o      <= 1'b0;
            reserved_bit_seen_o <= 1'b0;
        end else begin
            config_error_o      <= err_d;
            reserved_bit_seen_o <= out_rsv_d;
        end
    end

endmodule

/* bench/mrt_checker.sv */
`timescale 1ns/1ps
module mrt_checker (
    // Clock, reset and device state
    input wire logic               mclk_i,
    input wire logic               rst_n_i,
    input wire logic               preamble_2ck_i,
    input wire logic               write_active_i,
    input wire logic               write_leveling_i,
    input wire logic [2:0]         nominal_termination_value_i,
    input wire logic [4:0]         additive_delay_i,
    input wire logic [2:0]         parity_delay_i,
    // Decoded settings
    input wire logic [2:0]         write_termination_value_o,
    input wire logic               dynamic_term_en_o,
    input wire logic [2:0]         active_term_code_o,
    input wire mrt_pkg::mrt_term_e active_term_src_o,
    input wire logic [1:0]         low_power_self_refresh_range_o,
    input wire logic               automatic_range_self_refresh_o,
    input wire logic [4:0]         write_cas_delay_o,
    input wire logic               write_cas_delay_ok_o,
    input wire logic [6:0]         overall_write_delay_o,
    input wire logic               write_crc_en_o,
    input wire logic [3:0]         write_frame_ui_o
);
    import mrt_pkg::*;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////
    a_auto_range: assert property (automatic_range_self_refresh_o == (low_power_self_refresh_range_o == 2'h3))
        else $error("auto range flag wrong");
    a_dyn_enable: assert property (dynamic_term_en_o == (write_termination_value_o inside {[3'h1:3'h4]}))
        else $error("dynamic enable wrong");
    a_cwd_legal: assert property (write_cas_delay_ok_o |->
        write_cas_delay_o inside {5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0E, 5'h10, 5'h12, 5'h14})
        else $error("write cas delay off table");
    a_pre2_floor: assert property ($past(preamble_2ck_i) |-> write_cas_delay_o inside {5'h00, [5'h0E:5'h14]})
        else $error("short delay with long preamble");
    // Outputs lag inputs by one edge, so skip the edge after reset
    a_wl_sum: assert property ($past(rst_n_i) |-> overall_write_delay_o ==
        7'($past(additive_delay_i)) + 7'($past(parity_delay_i)) + 7'(write_cas_delay_o))
        else $error("overall write delay wrong");
    a_frame_len: assert property (write_frame_ui_o == (write_crc_en_o ? 4'hA : 4'h8))
        else $error("frame length wrong");
    a_write_term: assert property (active_term_src_o == MRT_TERM_WRITE |->
        $past(write_active_i) && !$past(write_leveling_i) && active_term_code_o == write_termination_value_o)
        else $error("write termination misapplied");
    a_write_used: assert property ($past(rst_n_i) && $past(write_active_i) && !$past(write_leveling_i)
        && dynamic_term_en_o && $past(dynamic_term_en_o) |-> active_term_src_o == MRT_TERM_WRITE)
        else $error("write termination not applied");
    a_level_nom: assert property ($past(write_leveling_i) |-> active_term_src_o == MRT_TERM_NOMINAL)
        else $error("leveling not nominal");
    a_nom_code: assert property ($past(rst_n_i) && active_term_src_o == MRT_TERM_NOMINAL |->
        active_term_code_o == $past(nominal_termination_value_i))
        else $error("nominal code wrong");
    c_write_term: cover property (active_term_src_o == MRT_TERM_WRITE);
    c_auto_range: cover property (automatic_range_self_refresh_o);
    c_crc_frame: cover property (write_frame_ui_o == 4'hA);
endmodule

bind mrt_mode_regs mrt_checker u_chk (.*);

/* bench/mrt_ctrl_model.sv */
`timescale 1ns/1ps
module mrt_ctrl_model (
    // Link clock and request
    input  wire logic         link_clk_i,
    input  wire logic         go_i,
    input  wire logic [21:0]  word_i,
    // Pins toward the device
    output mrt_pkg::mrt_pins_s pins_o
);
    import mrt_pkg::*;
    mrt_pins_s pins_q = '1;
    assign pins_o = pins_q;
    // Idle address lines flip so a stale value never looks valid
    always @(posedge link_clk_i) begin
        if (go_i) begin
            pins_q <= {5'h08, word_i[21:17], word_i[13:0]};
        end else begin
            pins_q <= {5'h1F, ~pins_q[18:0]};
        end
    end
endmodule

/* bench/mrt_mode_regs_tb_top.sv */
`timescale 1ns/1ps
module mrt_mode_regs_tb_top;
    import mrt_pkg::*;
    logic        mclk_i = 1'b0;
    logic        link_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        go = 1'b0;
    logic [21:0] word = '0;
    logic        pre2 = 1'b0, gear = 1'b0, wact = 1'b0, wlev = 1'b0;
    logic [2:0]  nom = 3'h5, pl = 3'h2, wtv, atc, wcl;
    logic [4:0]  al = 5'h07, cwd;
    logic [1:0]  srr, mpf;
    logic [6:0]  owd;
    logic [3:0]  fui;
    logic        dte, automatic_range_self_refresh, cok, crc, cerr, rsv;
    mrt_term_e   src;
    mrt_pins_s   pins;
    int          fails = 0, comparisons = 0;
    logic [7:0]  cw [8] = '{8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0E, 8'h10, 8'h12, 8'h14};

    initial forever #25 mclk_i = ~mclk_i;
    initial begin
        #17;
        forever #62.5 link_clk = ~link_clk;
    end

    mrt_ctrl_model u_ctrl (.link_clk_i(link_clk), .go_i(go), .word_i(word), .pins_o(pins));
    mrt_mode_regs u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n), .link_clk_i(link_clk), .pins_i(pins),
        .preamble_2ck_i(pre2), .gear_down_i(gear), .write_active_i(wact), .write_leveling_i(wlev),
        .nominal_termination_value_i(nom), .additive_delay_i(al), .parity_delay_i(pl),
        .write_termination_value_o(wtv), .dynamic_term_en_o(dte), .active_term_code_o(atc),
        .active_term_src_o(src), .low_power_self_refresh_range_o(srr), .automatic_range_self_refresh_o(automatic_range_self_refresh),
        .write_cas_delay_o(cwd), .write_cas_delay_ok_o(cok), .overall_write_delay_o(owd),
        .write_crc_en_o(crc), .write_frame_ui_o(fui), .mpr_read_format_o(mpf),
        .write_cmd_latency_o(wcl), .config_error_o(cerr), .reserved_bit_seen_o(rsv));
    ////////////////////////////////////////
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %0h seen %0h", n, e, g);
        end
    endtask

    // Spacing well past the capture busy window, or the command is dropped
    task automatic mrs(logic [2:0] sel, logic [21:0] f);
        @(posedge link_clk);
        go <= 1'b1;
        word <= f | {1'b0, sel, 18'h0};
        @(posedge link_clk);
        go <= 1'b0;
        repeat (10) @(posedge link_clk);
    endtask

    task automatic t_cwd();
        logic [7:0] e;
        for (int p = 0; p < 2; p++) begin
            @(posedge mclk_i) pre2 <= p[0];
            for (int c = 0; c < 8; c++) begin
                mrs(MRT_SEL_SECOND, 22'(c) << 3);
                e = (p == 1 && c < 4) ? 8'h00 : cw[c];
                chk("cwd", e, cwd);
                chk("cwd_ok", e != 8'h00, cok);
                chk("wl", e + al + pl, owd);
                chk("cerr", p == 1 && c < 4, cerr);
            end
        end
        @(posedge mclk_i) pre2 <= 1'b0;
    endtask

    task automatic t_gear();
        @(posedge mclk_i) gear <= 1'b1;
        for (int c = 0; c < 3; c++) begin
            mrs(MRT_SEL_SECOND, 22'(c) << 3);
            chk("gear_cerr", c != 1, cerr);
        end
        @(posedge mclk_i) gear <= 1'b0;
    endtask

    task automatic t_term();
        logic d;
        for (int c = 0; c < 8; c++) begin
            d = c inside {[1:4]};
            @(posedge mclk_i) nom <= (c == 2) ? 3'h0 : 3'h5;
            mrs(MRT_SEL_SECOND, 22'(c) << 9);
            chk("wterm", c, wtv);
            chk("dyn_en", d, dte);
            chk("cerr", c > 4, cerr);
            @(posedge mclk_i) wact <= 1'b1;
            repeat (2) @(negedge mclk_i);
            chk("act_code", d ? c : nom, atc);
            chk("act_src", d, src);
            @(posedge mclk_i) wlev <= 1'b1;
            repeat (2) @(negedge mclk_i);
            chk("lev_src", 0, src);
            chk("lev_code", nom, atc);
            @(posedge mclk_i) {wact, wlev} <= 2'h0;
        end
    endtask

    task automatic t_srr();
        for (int c = 0; c < 4; c++) begin
            mrs(MRT_SEL_SECOND, (22'(c) << 6) | (22'(c[0]) << 12));
            chk("srr", c, srr);
            chk("auto", c == 3, automatic_range_self_refresh);
            chk("frame", c[0] ? 8'h0A : 8'h08, fui);
            chk("crc_en", c[0], crc);
        end
    endtask

    task automatic t_third();
        for (int c = 0; c < 4; c++) begin
            mrs(MRT_SEL_THIRD, (22'(c) << 11) | (22'(3 - c) << 9));
            chk("mpr_fmt", c, mpf);
            chk("cmd_lat", 7 - c, wcl);
            chk("cerr", c == 0 || c == 3, cerr);
            chk("srr_held", 3, srr);
        end
    endtask

    // Other selects, the unused code among them, must touch nothing
    task automatic t_select();
        for (int s = 0; s < 8; s++) begin
            if (s != 2 && s != 3) begin
                mrs(3'(s), 22'h000640);
                chk("srr_keep", 3, srr);
                chk("mpf_keep", 3, mpf);
            end
        end
    endtask

    task automatic t_rsv();
        logic [2:0] rs [7] = '{3'h2, 3'h2, 3'h2, 3'h2, 3'h3, 3'h3, 3'h3};
        int         rb [7] = '{8, 2, 1, 0, 21, 17, 13};
        for (int i = 0; i < 7; i++) begin
            mrs(rs[i], 22'h1 << rb[i]);
            chk("rsv_set", 1, rsv);
            mrs(rs[i], 22'h0);
            chk("rsv_clr", 0, rsv);
        end
    endtask

    task automatic wrap_up();
        if (fails == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge mclk_i);
        rst_n <= 1'b1;
        repeat (4) @(posedge link_clk);
        t_cwd();
        t_gear();
        t_term();
        t_srr();
        t_third();
        t_select();
        t_rsv();
        wrap_up();
    end

    initial begin
        #200000;
        fails++;
        wrap_up();
    end
endmodule
